//--- rtl/input_capture_channel.sv
// Input capture channel with AXI4-Lite register access
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Stop-in-idle set halts capture during Idle; mode 111 wake irq still fires
// - Timer select: set second timer, clear third
// - Interrupt every one to four captures
// - Overflow flag read-only, hardware cleared, resets zero
// - Not-empty bit shows unread captured values
// - Mode 111: rising-edge wake interrupt in Sleep/Idle
// - Modes 000 and 110 disable the channel
// - Modes 100/101 capture every 4th/16th rise
// - Mode 011 rising, mode 010 falling capture
// - Mode 001 both edges, interrupt every capture
// - Unimplemented control bits read as zero
module input_capture_channel
#(
    parameter int unsigned depth = capture_pkg::fifo_depth
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [capture_pkg::addr_width-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [capture_pkg::data_width-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [capture_pkg::addr_width-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [capture_pkg::data_width-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic capture_pin,
    input wire logic [15:0] second_timer_count,
    input wire logic [15:0] third_timer_count,
    input wire capture_pkg::power_t power_state,
    output logic capture_irq
);
    import capture_pkg::*;

    control_t ctrl;
    control_t next_ctrl;
    logic overflow_flag;
    logic next_overflow_flag;
    logic [2:0] sync;
    logic [3:0] edge_count;
    logic [3:0] next_edge_count;
    logic [1:0] cap_count;
    logic [1:0] next_cap_count;
    logic next_irq;
    logic aw_held;
    logic w_held;
    logic [addr_width-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic next_w_held;
    logic [addr_width-1:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [15:0] fifo_head;
    logic fifo_not_empty;
    logic fifo_full;
    logic capture_event;
    logic rise;
    logic fall;
    logic halted;
    logic do_read;
    logic ctrl_write;
    logic pop;

    function automatic logic [15:0] control_word(control_t c, logic ov,
                                                 logic ne);
        logic [15:0] w;
        w = 16'h0000;
        w[stop_in_idle_bit] = c.stop_in_idle;
        w[timer_select_bit] = c.timer_select;
        w[cpi_lsb+:2] = c.captures_per_interrupt;
        w[overflow_bit] = ov;
        w[not_empty_bit] = ne;
        w[mode_lsb+:3] = c.capture_mode_select;
        return w;
    endfunction

    // Two stages for metastability, third for edge history
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sync <= 3'b000;
        else
            sync <= {sync[1:0], capture_pin};
    end
    assign rise = sync[1] && !sync[2];
    assign fall = !sync[1] && sync[2];

    assign halted = ctrl.stop_in_idle && power_state.cpu_idle;

    always_comb
    begin
        capture_event = 1'b0;
        next_edge_count = edge_count;
        if (!halted)
        begin
            case (ctrl.capture_mode_select)
                mode_every_edge: capture_event = rise || fall;
                mode_falling: capture_event = fall;
                mode_rising: capture_event = rise;
                mode_rise_4, mode_rise_16:
                begin
                    if (rise)
                    begin
                        if (edge_count == ((ctrl.capture_mode_select ==
                            mode_rise_4) ? prescale_four : prescale_sixteen))
                        begin
                            capture_event = 1'b1;
                            next_edge_count = 4'h0;
                        end
                        else
                            next_edge_count = edge_count + 4'h1;
                    end
                end
                default: capture_event = 1'b0;
            endcase
        end
    end

    // Interrupt pulse generation
    always_comb
    begin
        next_cap_count = cap_count;
        next_irq = 1'b0;
        if (ctrl.capture_mode_select == mode_wake)
            next_irq = rise && (power_state.cpu_sleep ||
                                power_state.cpu_idle);
        else if (capture_event)
        begin
            if (ctrl.capture_mode_select == mode_every_edge ||
                cap_count == ctrl.captures_per_interrupt)
            begin
                next_irq = 1'b1;
                next_cap_count = 2'b00;
            end
            else
                next_cap_count = cap_count + 2'b01;
        end
    end

    // Register bus: write side
    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        ctrl_write = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (next_aw_held && next_w_held && !s_axi_bvalid)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            ctrl_write = (next_aw_addr == control_offset);
            next_bresp = (ctrl_write || next_aw_addr == buffer_offset) ?
                         resp_okay : resp_slverr;
        end
    end

    // Control register: only the low half is wide enough to matter
    always_comb
    begin
        next_ctrl = ctrl;
        if (ctrl_write)
        begin
            if (next_w_strb[1])
                next_ctrl.stop_in_idle = next_w_data[stop_in_idle_bit];
            if (next_w_strb[0])
            begin
                next_ctrl.timer_select = next_w_data[timer_select_bit];
                next_ctrl.captures_per_interrupt = next_w_data[cpi_lsb+:2];
                next_ctrl.capture_mode_select =
                    capture_mode_t'(next_w_data[mode_lsb+:3]);
            end
        end
    end

    // Register bus: read side; reading the buffer pops the oldest value
    assign do_read = s_axi_arvalid && s_axi_arready;
    assign pop = do_read && (s_axi_araddr == buffer_offset);
    always_comb
    begin
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (do_read)
        begin
            next_rvalid = 1'b1;
            next_rresp = resp_okay;
            next_rdata = 32'h00000000;
            if (s_axi_araddr == control_offset)
                next_rdata[15:0] = control_word(ctrl, overflow_flag,
                                                fifo_not_empty);
            // Empty reads return zero, never stale or unset storage
            else if (s_axi_araddr == buffer_offset)
                next_rdata[15:0] = fifo_not_empty ? fifo_head : 16'h0000;
            else
                next_rresp = resp_slverr;
        end
    end

    // Overflow is set by a capture into a full buffer not read that cycle, cleared when off
    always_comb
    begin
        next_overflow_flag = overflow_flag;
        if (capture_event && fifo_full && !pop)
            next_overflow_flag = 1'b1;
        else if (ctrl.capture_mode_select == mode_off)
            next_overflow_flag = 1'b0;
    end

    capture_fifo #(.width(16), .depth(depth)) fifo_i
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .push(capture_event),
        .push_data(ctrl.timer_select ? second_timer_count
                                     : third_timer_count),
        .pop(pop),
        .flush(ctrl.capture_mode_select == mode_off),
        .head(fifo_head),
        .not_empty(fifo_not_empty),
        .full(fifo_full)
    );

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl <= '{stop_in_idle: control_reset[stop_in_idle_bit],
                timer_select: control_reset[timer_select_bit],
                captures_per_interrupt: control_reset[cpi_lsb+:2],
                capture_mode_select:
                    capture_mode_t'(control_reset[mode_lsb+:3])};
            overflow_flag <= 1'b0;
            edge_count <= 4'h0;
            cap_count <= 2'b00;
            capture_irq <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= resp_okay;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= resp_okay;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            overflow_flag <= next_overflow_flag;
            // Any control register write restarts both counters
            edge_count <= ctrl_write ? 4'h0 : next_edge_count;
            cap_count <= ctrl_write ? 2'b00 : next_cap_count;
            capture_irq <= next_irq;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            s_axi_awready <= !next_aw_held && !s_axi_awready;
            s_axi_wready <= !next_w_held && !s_axi_wready;
            s_axi_arready <= !next_rvalid && !s_axi_arready;
        end
    end

    logic [15:0] last_ctrl_word;
    assign last_ctrl_word = control_word(ctrl, overflow_flag, fifo_not_empty);

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ctrl_zero_bits_a: assert property (last_ctrl_word[15:14] == 2'b00 &&
        last_ctrl_word[12:8] == 5'h00)
        else $error("unimplemented control bits not zero");
    halt_no_capture_a: assert property (halted |-> !capture_event)
        else $error("capture while halted in idle");
    off_no_capture_a: assert property ((ctrl.capture_mode_select ==
        mode_off || ctrl.capture_mode_select == mode_unused ||
        ctrl.capture_mode_select == mode_wake) |-> !capture_event)
        else $error("capture while disabled");
    rise_capture_a: assert property ((ctrl.capture_mode_select ==
        mode_rising && !halted && rise) |-> capture_event)
        else $error("rising edge missed");
    fall_capture_a: assert property ((ctrl.capture_mode_select ==
        mode_falling && !halted) |-> (capture_event == fall))
        else $error("falling capture wrong");
    both_edge_irq_a: assert property ((ctrl.capture_mode_select ==
        mode_every_edge && capture_event) |=> capture_irq)
        else $error("every-edge irq missing");
    wake_irq_a: assert property ((ctrl.capture_mode_select == mode_wake &&
        rise && !power_state.cpu_sleep && !power_state.cpu_idle)
        |=> !capture_irq)
        else $error("wake irq while running");
    overflow_set_a: assert property ((capture_event && fifo_full && !pop)
        |=> overflow_flag)
        else $error("overflow not flagged");
    prescale_a: assert property ((ctrl.capture_mode_select == mode_rise_4 &&
        capture_event) |-> edge_count == prescale_four)
        else $error("prescale count wrong");
    timer_pick_a: assert property ((capture_event && !fifo_full &&
        !fifo_not_empty && !pop) |=> fifo_head ==
        $past(ctrl.timer_select ? second_timer_count : third_timer_count))
        else $error("wrong timer captured");
    ne_bit_a: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == control_offset |=> s_axi_rdata[not_empty_bit] ==
        $past(fifo_not_empty))
        else $error("not-empty bit wrong");

    cap_rise_c: cover property (ctrl.capture_mode_select == mode_rising
        && capture_event);
    cap_16_c: cover property (ctrl.capture_mode_select == mode_rise_16
        && capture_event);
    overflow_c: cover property (capture_event && fifo_full);
    irq_c: cover property (capture_irq &&
        ctrl.captures_per_interrupt == 2'b11);
endmodule
`default_nettype wire

//--- rtl/capture_pkg.sv
// Package with register layout, modes and structs of the capture channel
package capture_pkg;
    localparam int unsigned data_width = 32;
    localparam int unsigned addr_width = 4;
    localparam logic [addr_width-1:0] control_offset = 4'h0;
    localparam logic [addr_width-1:0] buffer_offset = 4'h4;
    localparam int unsigned stop_in_idle_bit = 13;
    localparam int unsigned timer_select_bit = 7;
    localparam int unsigned cpi_lsb = 5;
    localparam int unsigned overflow_bit = 4;
    localparam int unsigned not_empty_bit = 3;
    localparam int unsigned mode_lsb = 0;
    localparam logic [15:0] control_reset = 16'h0000;
    localparam int unsigned fifo_depth = 4;
    localparam logic [3:0] prescale_four = 4'h3;
    localparam logic [3:0] prescale_sixteen = 4'hf;
    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;

    typedef enum logic [2:0]
    {
        mode_off = 3'b000,
        mode_every_edge = 3'b001,
        mode_falling = 3'b010,
        mode_rising = 3'b011,
        mode_rise_4 = 3'b100,
        mode_rise_16 = 3'b101,
        mode_unused = 3'b110,
        mode_wake = 3'b111
    } capture_mode_t;

    typedef struct packed
    {
        logic stop_in_idle;
        logic timer_select;
        logic [1:0] captures_per_interrupt;
        capture_mode_t capture_mode_select;
    } control_t;

    typedef struct packed
    {
        logic cpu_idle;
        logic cpu_sleep;
    } power_t;
endpackage

//--- rtl/capture_fifo.sv
// Small FIFO that holds captured timer values, oldest first
`timescale 1ns/10ps
`default_nettype none
module capture_fifo
#(
    parameter int unsigned width = 16,
    parameter int unsigned depth = 4
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic push,
    input wire logic [width-1:0] push_data,
    input wire logic pop,
    input wire logic flush,
    output logic [width-1:0] head,
    output logic not_empty,
    output logic full
);
    localparam int unsigned pw = $clog2(depth);
    logic [width-1:0] mem [depth];
    logic [pw-1:0] wr_ptr;
    logic [pw-1:0] rd_ptr;
    logic [pw:0] count;
    logic [pw-1:0] next_wr_ptr;
    logic [pw-1:0] next_rd_ptr;
    logic [pw:0] next_count;
    logic do_push;
    logic do_pop;

    assign full = (count == (pw+1)'(depth));
    assign not_empty = (count != '0);
    assign head = mem[rd_ptr];
    assign do_push = push && !full;
    assign do_pop = pop && not_empty;

    always_comb
    begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (flush)
        begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count = '0;
        end
        else
        begin
            if (do_push)
                next_wr_ptr = (wr_ptr == pw'(depth-1)) ? '0 : wr_ptr + 1'b1;
            if (do_pop)
                next_rd_ptr = (rd_ptr == pw'(depth-1)) ? '0 : rd_ptr + 1'b1;
            if (do_push && !do_pop)
                next_count = count + 1'b1;
            else if (do_pop && !do_push)
                next_count = count - 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // Storage needs no reset; reads are gated by the count
    always_ff @(posedge aclk)
    begin
        if (do_push && !flush)
            mem[wr_ptr] <= push_data;
    end
endmodule
`default_nettype wire

//--- bench/pin_timer_model.sv
// Model of the capture pin source and the two system timers
`timescale 1ns/10ps
`default_nettype none
module pin_timer_model
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_drive,
    input wire logic tick,
    output logic capture_pin,
    output logic [15:0] second_timer_count,
    output logic [15:0] third_timer_count
);
    logic [15:0] ticks;
    initial
        capture_pin = 1'b0;
    // Pin moves off the clock edge, as an unrelated source would
    always @(pin_drive)
        capture_pin <= #1.3 pin_drive;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ticks <= 16'h0000;
        else if (tick)
            ticks <= ticks + 16'h0001;
    end
    // Timers advance only on request, so each capture has one known value
    assign second_timer_count = 16'h1000 + ticks;
    assign third_timer_count = 16'h8000 + 16'h0003 * ticks;
endmodule
`default_nettype wire

//--- bench/tb_input_capture_channel.sv
// Self-checking bench for the input capture channel
`timescale 1ns/10ps
`default_nettype none
`define check(what, exp, got) \
begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
        bad_count++; \
        $display("unexpected %s expected %h seen %h", what, exp, got); \
    end \
end
module tb_input_capture_channel;
    import capture_pkg::*;
    logic aclk, aresetn, pin_drive, tick, capture_pin, capture_irq;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
    logic [15:0] second_timer_count, third_timer_count;
    power_t power_state;
    int bad_count, num_checks, ticks, irq_seen;

    input_capture_channel input_capture_channel_i
    (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .capture_pin(capture_pin),
        .second_timer_count(second_timer_count),
        .third_timer_count(third_timer_count),
        .power_state(power_state), .capture_irq(capture_irq)
    );
    pin_timer_model pin_timer_model_i
    (
        .aclk(aclk), .aresetn(aresetn), .pin_drive(pin_drive),
        .tick(tick), .capture_pin(capture_pin),
        .second_timer_count(second_timer_count),
        .third_timer_count(third_timer_count)
    );

    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk)
        if (capture_irq === 1'b1)
            irq_seen++;

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
            begin
                last_resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
            begin
                d = s_axi_rdata;
                last_resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask

    // One high and one low phase, long enough for sync, capture and irq
    task automatic pulse();
        @(posedge aclk);
        pin_drive <= 1'b1;
        repeat (6) @(posedge aclk);
        pin_drive <= 1'b0;
        repeat (6) @(posedge aclk);
        tick <= 1'b1;
        @(posedge aclk);
        tick <= 1'b0;
        ticks++;
    endtask

    task automatic run_mode(input logic [15:0] ctrl, input int pulses,
        input int first, input int period, input int per, input int irqs);
        int t0, i0, ncap, idx;
        logic [31:0] d;
        logic [15:0] exp;
        axi_write(control_offset, 32'h0000_0000);
        axi_write(control_offset, {16'h0000, ctrl});
        t0 = ticks;
        i0 = irq_seen;
        for (int p = 0; p < pulses; p++)
            pulse();
        ncap = (pulses > first) ?
            ((pulses - 1 - first) / period + 1) * per : 0;
        for (int k = 0; k < ncap; k++)
        begin
            axi_read(control_offset, d);
            `check("not empty", 1'b1, d[not_empty_bit])
            idx = t0 + first + (k / per) * period;
            exp = ctrl[timer_select_bit] ? 16'h1000 + idx[15:0]
                : 16'h8000 + 16'h0003 * idx[15:0];
            axi_read(buffer_offset, d);
            `check("captured value", {16'h0000, exp}, d)
        end
        axi_read(control_offset, d);
        `check("control after drain", {16'h0000, ctrl}, d)
        `check("interrupt count", irqs, irq_seen - i0)
    endtask

    task automatic t_reset_regs();
        logic [31:0] d;
        axi_read(control_offset, d);
        `check("control reset", {16'h0000, control_reset}, d)
        axi_write(control_offset, 32'hffff_ffff);
        axi_read(control_offset, d);
        `check("writable bits", 32'h0000_20e7, d)
        axi_write(control_offset, 32'h0000_0000);
        axi_read(4'h8, d);
        `check("unmapped response", resp_slverr, last_resp)
        `check("unmapped data", 32'h0000_0000, d)
        $display("test reset_regs done");
    endtask

    task automatic t_capture_modes();
        run_mode(16'h0083, 2, 0, 1, 1, 2);
        run_mode(16'h0002, 2, 0, 1, 1, 2);
        run_mode(16'h00e1, 2, 0, 1, 2, 4);
        run_mode(16'h0004, 5, 3, 4, 1, 1);
        run_mode(16'h0085, 17, 15, 16, 1, 1);
        run_mode(16'h0000, 2, 2, 1, 1, 0);
        run_mode(16'h0006, 2, 2, 1, 1, 0);
        $display("test capture_modes done");
    endtask

    task automatic t_interrupt_rate();
        run_mode(16'h0023, 4, 0, 1, 1, 2);
        run_mode(16'h0043, 4, 0, 1, 1, 1);
        run_mode(16'h0063, 4, 0, 1, 1, 1);
        $display("test interrupt_rate done");
    endtask

    task automatic t_idle_and_wake();
        power_state <= '{cpu_idle: 1'b1, cpu_sleep: 1'b0};
        run_mode(16'h2003, 2, 2, 1, 1, 0);
        run_mode(16'h0003, 2, 0, 1, 1, 2);
        power_state <= '{cpu_idle: 1'b0, cpu_sleep: 1'b1};
        run_mode(16'h0007, 2, 2, 1, 1, 2);
        power_state <= '{cpu_idle: 1'b0, cpu_sleep: 1'b0};
        run_mode(16'h0007, 2, 2, 1, 1, 0);
        $display("test idle_and_wake done");
    endtask

    task automatic t_overflow();
        logic [31:0] d;
        int t0;
        int idx;
        logic [15:0] exp;
        axi_write(control_offset, 32'h0000_0000);
        axi_write(control_offset, 32'h0000_0003);
        t0 = ticks;
        repeat (6) pulse();
        axi_read(control_offset, d);
        `check("overflow set", 32'h0000_001b, d)
        for (int k = 0; k < 4; k++)
        begin
            idx = t0 + k;
            exp = 16'h8000 + 16'h0003 * idx[15:0];
            axi_read(buffer_offset, d);
            `check("oldest first", {16'h0000, exp}, d)
        end
        axi_read(control_offset, d);
        `check("drained with overflow", 32'h0000_0013, d)
        axi_read(buffer_offset, d);
        `check("empty buffer", 32'h0000_0000, d)
        axi_write(control_offset, 32'h0000_0000);
        axi_read(control_offset, d);
        `check("overflow cleared", 32'h0000_0000, d)
        $display("test overflow done");
    endtask

    initial
    begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        results();
    end

    initial
    begin
        aresetn = 1'b0;
        pin_drive = 1'b0;
        tick = 1'b0;
        power_state = '{cpu_idle: 1'b0, cpu_sleep: 1'b0};
        s_axi_awaddr = 4'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 4'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_regs();
        t_capture_modes();
        t_interrupt_rate();
        t_idle_and_wake();
        t_overflow();
        results();
    end
endmodule
`default_nettype wire
